// file: design/msm_source_map.sv
// Purpose: attaches an interrupt source id to each interrupt write
// Assumes: one write per cycle, inputs synchronous to clock
// Notes:   one cycle of latency; ids derived by fixed linear offsets
`timescale 1ns/1ps
`default_nettype none
module msm_source_map
  import msm_pkg::*;
#(
  parameter int unsigned RID_N    = MSM_RID_N,
  parameter int unsigned RID_IN_W = MSM_RID_IN_W,
  parameter int unsigned STREAM_W = MSM_STREAM_W,
  parameter int unsigned SID_W    = MSM_SID_W,
  parameter int unsigned XLT_N    = MSM_XLT_N,
  parameter int unsigned GRP_W    = MSM_GRP_W,
  parameter logic [XLT_N*GRP_W-1:0] XLT_MAP = MSM_XLT_MAP,
  parameter logic [SID_W-1:0] OFFSET_A = MSM_OFFSET_A,
  parameter int unsigned CONST_B  = MSM_CONST_B,
  parameter int unsigned CONST_C  = MSM_CONST_C,
  parameter msm_bad_mode_t BAD_MODE = MSM_BAD_POISON
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // Incoming interrupt write
  input  wire logic                   req_valid,
  input  wire msm_kind_t              req_kind,
  input  wire logic [STREAM_W-1:0]    req_stream_id,
  input  wire logic [RID_IN_W-1:0]    req_requester_id,
  input  wire logic [GRP_W-1:0]       req_home_group,
  input  wire logic [$clog2(XLT_N)-1:0] req_target,
  // Outgoing interrupt to translator
  output logic                        out_valid_q,
  output logic [SID_W-1:0]            out_source_id_q,
  output logic [GRP_W-1:0]            out_group_q,
  output logic [$clog2(XLT_N)-1:0]    out_target_q,
  output logic                        out_poisoned_q,
  // Illegal write outcomes
  output logic                        out_abort_q,
  output logic                        out_write_ignored_q
);

  localparam int unsigned TGT_W = $clog2(XLT_N);
  // All-ones id is kept back so it aliases no legal source
  localparam logic [SID_W-1:0] POISON_ID = '1;
  localparam logic [STREAM_W-1:0] OFF_B =
    STREAM_W'(longint'(CONST_B) << RID_N);
  localparam logic [SID_W-1:0] OFF_C =
    SID_W'(longint'(CONST_C) << RID_N);

  // Elaboration checks
  if (RID_N < 1 || RID_N > RID_IN_W) begin : g_bad_n
    $error("msm_source_map: RID_N out of range");
  end
  if (STREAM_W <= RID_N || SID_W <= RID_N) begin : g_bad_sw
    $error("msm_source_map: id widths must exceed RID_N");
  end
  if (SID_W < STREAM_W) begin : g_bad_sid
    $error("msm_source_map: source id narrower than stream id");
  end
  if ((longint'(CONST_B) >> (STREAM_W - RID_N)) != 0) begin : g_bad_b
    $error("msm_source_map: CONST_B overflows stream id");
  end
  if ((longint'(CONST_C) >> (SID_W - RID_N)) != 0) begin : g_bad_c
    $error("msm_source_map: CONST_C overflows source id");
  end
  if (XLT_N < 2) begin : g_bad_x
    $error("msm_source_map: at least two translators required");
  end

  // Adder paths
  msm_id_if #(.IN_W(RID_N),    .OUT_W(STREAM_W)) rc_stream ();
  msm_id_if #(.IN_W(STREAM_W), .OUT_W(SID_W))    stream_sid ();
  msm_id_if #(.IN_W(RID_N),    .OUT_W(SID_W))    rc_sid ();

  logic [STREAM_W-1:0] stream_sel;
  logic                in_group;
  logic                kind_ok;
  logic                wrap;
  logic [SID_W-1:0]    sid_d;
  logic                legal;

  // Low N requester bits feed both root complex forms
  assign rc_stream.id_in = req_requester_id[RID_N-1:0];
  assign rc_sid.id_in    = req_requester_id[RID_N-1:0];
  assign stream_sid.id_in = stream_sel;

  msm_id_adder #(
    .IN_W   (RID_N),
    .OUT_W  (STREAM_W),
    .OFFSET (OFF_B)
  ) u_rc_stream (
    .ids (rc_stream)
  );

  msm_id_adder #(
    .IN_W   (STREAM_W),
    .OUT_W  (SID_W),
    .OFFSET (OFFSET_A)
  ) u_stream_sid (
    .ids (stream_sid)
  );

  msm_id_adder #(
    .IN_W   (RID_N),
    .OUT_W  (SID_W),
    .OFFSET (OFF_C)
  ) u_rc_sid (
    .ids (rc_sid)
  );

  msm_group_check #(
    .XLT_N (XLT_N),
    .GRP_W (GRP_W),
    .MAP   (XLT_MAP),
    .TGT_W (TGT_W)
  ) u_group (
    .target     (req_target),
    .home_group (req_home_group),
    .in_group   (in_group)
  );

  // Stream id reaches the adder untouched, except for MSM_KIND_RC_XLAT writes, which feed it rc_stream.id_out
  always_comb begin
    stream_sel = req_stream_id;
    if (req_kind == MSM_KIND_RC_XLAT) begin
      stream_sel = rc_stream.id_out;
    end
  end

  // Source id selection per requester kind
  always_comb begin
    sid_d   = stream_sid.id_out;
    wrap    = stream_sid.wrap;
    kind_ok = 1'h0;
    unique case (req_kind)
      MSM_KIND_TRANSLATED: begin
        kind_ok = 1'h1;
      end
      MSM_KIND_RC_XLAT: begin
        kind_ok = 1'h1;
        wrap    = stream_sid.wrap | rc_stream.wrap;
      end
      MSM_KIND_RC_DIRECT: begin
        kind_ok = 1'h1;
        sid_d   = rc_sid.id_out;
        wrap    = rc_sid.wrap;
      end
      MSM_KIND_ASSIGNED: begin
        kind_ok = 1'h1;
        sid_d   = SID_W'(req_stream_id);
        wrap    = 1'h0;
      end
      MSM_KIND_PE, MSM_KIND_UNTRUSTED: begin
        kind_ok = 1'h0;
      end
      default: begin
        kind_ok = 1'h0;
      end
    endcase
  end

  // A wrapped or reserved id would alias, so it counts as illegal
  assign legal = kind_ok && in_group && !wrap &&
                 (sid_d != POISON_ID);

  // Interrupt output
  always_ff @(posedge clock) begin
    if (rst) begin
      out_valid_q    <= MSM_FLAG_RST;
      out_poisoned_q <= MSM_FLAG_RST;
      out_source_id_q <= '0;
      out_group_q    <= '0;
      out_target_q   <= '0;
    end else begin
      out_valid_q    <= req_valid &&
                        (legal || BAD_MODE == MSM_BAD_POISON);
      out_poisoned_q <= req_valid && !legal &&
                        BAD_MODE == MSM_BAD_POISON;
      out_source_id_q <= legal ? sid_d : POISON_ID;
      out_group_q    <= req_home_group;
      out_target_q   <= req_target;
    end
  end

  // Refusals of illegal writes
  always_ff @(posedge clock) begin
    if (rst) begin
      out_abort_q         <= MSM_FLAG_RST;
      out_write_ignored_q <= MSM_FLAG_RST;
    end else begin
      out_abort_q <= req_valid && !legal &&
                     BAD_MODE == MSM_BAD_ABORT;
      out_write_ignored_q <= req_valid && !legal &&
                             BAD_MODE == MSM_BAD_IGNORE;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_xlat_ok;
    req_valid && req_kind == MSM_KIND_TRANSLATED && in_group &&
    !stream_sid.wrap && stream_sid.id_out != POISON_ID;
  endsequence

  sequence s_direct_ok;
    req_valid && req_kind == MSM_KIND_RC_DIRECT && in_group &&
    !rc_sid.wrap && rc_sid.id_out != POISON_ID;
  endsequence

  sequence s_rc_xlat_ok;
    req_valid && req_kind == MSM_KIND_RC_XLAT && in_group &&
    !rc_stream.wrap && !stream_sid.wrap &&
    stream_sid.id_out != POISON_ID;
  endsequence

  sequence s_bad_source;
    req_valid && (req_kind == MSM_KIND_PE ||
                  req_kind == MSM_KIND_UNTRUSTED);
  endsequence

  translated_sid_a: assert property (
    s_xlat_ok |=> out_valid_q && !out_poisoned_q &&
      out_source_id_q == SID_W'($past(req_stream_id)) + OFFSET_A)
    else $error("translated source id wrong");

  direct_sid_a: assert property (
    s_direct_ok |=> out_valid_q && out_source_id_q ==
      SID_W'($past(req_requester_id[RID_N-1:0])) + OFF_C)
    else $error("direct root complex source id wrong");

  rc_chain_a: assert property (
    s_rc_xlat_ok |=> out_valid_q && out_source_id_q ==
      SID_W'(STREAM_W'($past(req_requester_id[RID_N-1:0])) + OFF_B)
      + OFFSET_A)
    else $error("root complex stream chain wrong");

  bad_source_a: assert property (
    s_bad_source |=> out_poisoned_q || out_abort_q ||
      out_write_ignored_q)
    else $error("processor write produced a legal id");

  foreign_group_a: assert property (
    req_valid && !in_group |=> !out_valid_q ||
      out_source_id_q == POISON_ID)
    else $error("foreign group write not neutralised");

  one_outcome_a: assert property (
    $onehot0({out_valid_q, out_abort_q, out_write_ignored_q}) &&
    (!out_poisoned_q || out_valid_q))
    else $error("more than one outcome for a write");

  no_alias_a: assert property (
    out_valid_q && !out_poisoned_q |-> out_source_id_q != POISON_ID)
    else $error("legal write carries reserved id");

  distinct_ids_a: assert property (
    s_xlat_ok ##1 (s_xlat_ok and
      (req_stream_id != $past(req_stream_id)))
    |=> out_source_id_q != $past(out_source_id_q))
    else $error("two stream ids share a source id");

  latency_a: assert property (
    (out_valid_q || out_abort_q || out_write_ignored_q) |->
      $past(req_valid))
    else $error("outcome without a write");

  group_kept_a: assert property (
    req_valid |=> out_group_q == $past(req_home_group))
    else $error("group not carried with id");

endmodule : msm_source_map
`default_nettype wire

// file: design/msm_pkg.sv
// Purpose: shared constants and types for the interrupt source-id mapper
// Assumes: identifier widths and offsets are fixed at elaboration
// Notes:   offsets are hardware constants, never changed after reset
package msm_pkg;

  // Identifier widths
  localparam int unsigned MSM_RID_N     = 16;
  localparam int unsigned MSM_RID_IN_W  = 16;
  localparam int unsigned MSM_STREAM_W  = 32;
  localparam int unsigned MSM_SID_W     = 32;

  // Translator grouping
  localparam int unsigned MSM_XLT_N     = 4;
  localparam int unsigned MSM_GRP_W     = 2;
  localparam logic [7:0]  MSM_XLT_MAP   = 8'h54;

  // Linear offsets
  localparam logic [31:0] MSM_OFFSET_A  = 32'h0000_0000;
  localparam int unsigned MSM_CONST_B   = 0;
  localparam int unsigned MSM_CONST_C   = 1;

  // Reset values
  localparam logic        MSM_FLAG_RST  = 1'h0;

  typedef enum logic [2:0] {
    MSM_KIND_TRANSLATED = 3'h0,
    MSM_KIND_RC_XLAT    = 3'h1,
    MSM_KIND_RC_DIRECT  = 3'h2,
    MSM_KIND_ASSIGNED   = 3'h3,
    MSM_KIND_PE         = 3'h4,
    MSM_KIND_UNTRUSTED  = 3'h5
  } msm_kind_t;

  typedef enum logic [1:0] {
    MSM_BAD_IGNORE = 2'h0,
    MSM_BAD_ABORT  = 2'h1,
    MSM_BAD_POISON = 2'h2
  } msm_bad_mode_t;

endpackage : msm_pkg

// file: design/msm_id_if.sv
// Purpose: carries one identifier through an offset adder
// Assumes: widths match the adder that serves it
// Notes:   wrap flags an overflow past the output width
`timescale 1ns/1ps
`default_nettype none
interface msm_id_if #(
  parameter int unsigned IN_W  = 16,
  parameter int unsigned OUT_W = 32
);
  logic [IN_W-1:0]  id_in;
  logic [OUT_W-1:0] id_out;
  logic             wrap;

  modport calc (input id_in, output id_out, output wrap);
  modport user (output id_in, input id_out, input wrap);
endinterface : msm_id_if
`default_nettype wire

// file: design/msm_id_adder.sv
// Purpose: zero-extends an identifier and adds a fixed offset
// Assumes: OUT_W not below IN_W
// Notes:   carry out is reported, never folded back into the range
`timescale 1ns/1ps
`default_nettype none
module msm_id_adder #(
  parameter int unsigned    IN_W   = 16,
  parameter int unsigned    OUT_W  = 32,
  parameter logic [OUT_W-1:0] OFFSET = '0
) (
  // Identifier path
  msm_id_if.calc ids
);
  logic [OUT_W:0] sum;

  if (OUT_W < IN_W) begin : g_bad_w
    $error("msm_id_adder: output narrower than input");
  end

  // Extra carry bit keeps a wrap visible
  assign sum        = {1'h0, OUT_W'(ids.id_in)} + {1'h0, OFFSET};
  assign ids.id_out = sum[OUT_W-1:0];
  assign ids.wrap   = sum[OUT_W];

endmodule : msm_id_adder
`default_nettype wire

// file: design/msm_group_check.sv
// Purpose: decides whether a target translator sits in the home group
// Assumes: translator-to-group map fixed at elaboration
// Notes:   targets beyond the map never match
`timescale 1ns/1ps
`default_nettype none
module msm_group_check #(
  parameter int unsigned              XLT_N = 4,
  parameter int unsigned              GRP_W = 2,
  parameter logic [XLT_N*GRP_W-1:0]   MAP   = '0,
  parameter int unsigned              TGT_W = 2
) (
  // Query
  input  wire logic [TGT_W-1:0] target,
  input  wire logic [GRP_W-1:0] home_group,
  // Answer
  output logic                  in_group
);
  logic [XLT_N-1:0] hit;

  for (genvar i = 0; i < XLT_N; i++) begin : g_xlt
    // Every translator of the group accepts alike
    assign hit[i] = (target == TGT_W'(i)) &&
                    (MAP[i*GRP_W +: GRP_W] == home_group);
  end

  assign in_group = |hit;

endmodule : msm_group_check
`default_nettype wire

// file: bench/msm_xlt_model.sv
// Purpose: downstream translator stand-in that takes issued interrupts
// Assumes: at most one interrupt per cycle
// Notes:   poisoned interrupts are refused, never delivered
`timescale 1ns/1ps
`default_nettype none
module msm_xlt_model
  import msm_pkg::*;
(
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // Interrupt from the mapper
  input  wire logic                 irq_valid,
  input  wire logic [MSM_SID_W-1:0] irq_source_id,
  input  wire logic [MSM_GRP_W-1:0] irq_group,
  input  wire logic                 irq_poisoned,
  // Delivered interrupt record
  output logic [15:0]               taken_count_q,
  output logic [MSM_SID_W-1:0]      taken_id_q,
  output logic [MSM_GRP_W-1:0]      taken_group_q
);
  // Any target of the group accepts, id read within its group
  always_ff @(posedge clock) begin
    if (rst) begin
      taken_count_q <= 16'h0000;
      taken_id_q    <= '0;
      taken_group_q <= '0;
    end else if (irq_valid && !irq_poisoned) begin
      taken_count_q <= taken_count_q + 16'h0001;
      taken_id_q    <= irq_source_id;
      taken_group_q <= irq_group;
    end
  end
endmodule : msm_xlt_model
`default_nettype wire

// file: bench/test_msm_source_map.sv
// Purpose: self-checking bench for the source id mapper
// Assumes: poison mode, offsets chosen nonzero below
// Notes:   one write at a time except one back to back pair, outcome checked one edge later
`timescale 1ns/1ps
`default_nettype none
module test_msm_source_map;
  import msm_pkg::*;
  // Nonzero offsets so each formula term is seen
  localparam logic [31:0] OFFS_A = 32'h0000_1000;
  localparam int unsigned C_B    = 2;
  localparam int unsigned C_C    = 3;

  logic        clock;
  logic        rst;
  logic        req_valid;
  msm_kind_t   req_kind;
  logic [31:0] req_stream_id;
  logic [15:0] req_requester_id;
  logic [1:0]  req_home_group;
  logic [1:0]  req_target;
  logic        out_valid_q;
  logic [31:0] out_source_id_q;
  logic [1:0]  out_group_q;
  logic        out_poisoned_q;
  logic        out_abort_q;
  logic        out_write_ignored_q;
  logic [1:0]  out_target_q;
  logic        abt_valid_q;
  logic        abt_abort_q;
  logic        ign_valid_q;
  logic        ign_ignored_q;
  logic [15:0] taken_count_q;
  logic [31:0] taken_id_q;
  logic [1:0]  taken_group_q;
  int          fail_count;
  int          compares;
  logic [15:0] exp_taken;

  always #5 clock = ~clock;

  msm_source_map #(.OFFSET_A(OFFS_A), .CONST_B(C_B), .CONST_C(C_C))
    i_msm_source_map (
    .clock(clock), .rst(rst), .req_valid(req_valid),
    .req_kind(req_kind), .req_stream_id(req_stream_id),
    .req_requester_id(req_requester_id),
    .req_home_group(req_home_group), .req_target(req_target),
    .out_valid_q(out_valid_q), .out_source_id_q(out_source_id_q),
    .out_group_q(out_group_q), .out_target_q(out_target_q),
    .out_poisoned_q(out_poisoned_q), .out_abort_q(out_abort_q),
    .out_write_ignored_q(out_write_ignored_q));

  // Same writes seen by the two refusing modes
  msm_source_map #(.OFFSET_A(OFFS_A), .CONST_B(C_B), .CONST_C(C_C),
    .BAD_MODE(MSM_BAD_ABORT)) i_msm_source_map_abort (
    .clock(clock), .rst(rst), .req_valid(req_valid),
    .req_kind(req_kind), .req_stream_id(req_stream_id),
    .req_requester_id(req_requester_id),
    .req_home_group(req_home_group), .req_target(req_target),
    .out_valid_q(abt_valid_q), .out_source_id_q(), .out_group_q(),
    .out_target_q(), .out_poisoned_q(), .out_abort_q(abt_abort_q),
    .out_write_ignored_q());

  msm_source_map #(.OFFSET_A(OFFS_A), .CONST_B(C_B), .CONST_C(C_C),
    .BAD_MODE(MSM_BAD_IGNORE)) i_msm_source_map_ignore (
    .clock(clock), .rst(rst), .req_valid(req_valid),
    .req_kind(req_kind), .req_stream_id(req_stream_id),
    .req_requester_id(req_requester_id),
    .req_home_group(req_home_group), .req_target(req_target),
    .out_valid_q(ign_valid_q), .out_source_id_q(), .out_group_q(),
    .out_target_q(), .out_poisoned_q(), .out_abort_q(),
    .out_write_ignored_q(ign_ignored_q));

  msm_xlt_model i_msm_xlt_model (
    .clock(clock), .rst(rst), .irq_valid(out_valid_q),
    .irq_source_id(out_source_id_q), .irq_group(out_group_q),
    .irq_poisoned(out_poisoned_q), .taken_count_q(taken_count_q),
    .taken_id_q(taken_id_q), .taken_group_q(taken_group_q));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic send(input msm_kind_t k, input logic [31:0] sid,
                      input logic [15:0] rid, input logic [1:0] grp,
                      input logic [1:0] tgt);
    @(posedge clock);
    req_valid        <= 1'h1;
    req_kind         <= k;
    req_stream_id    <= sid;
    req_requester_id <= rid;
    req_home_group   <= grp;
    req_target       <= tgt;
    @(posedge clock);
    req_valid <= 1'h0;
    #1;
  endtask : send

  task automatic expect_out(input logic v, input logic p,
                            input logic [31:0] id, input logic [1:0] grp);
    check({31'h0, out_valid_q}, {31'h0, v});
    check({31'h0, out_poisoned_q}, {31'h0, p});
    check({31'h0, out_abort_q | out_write_ignored_q}, 32'h0);
    check(out_source_id_q, id);
    if (v && !p) begin
      check({30'h0, out_group_q}, {30'h0, grp});
      exp_taken++;
    end
  endtask : expect_out

  task automatic t_translated;
    send(MSM_KIND_TRANSLATED, 32'h5, 16'h0, 2'h0, 2'h0);
    expect_out(1'h1, 1'h0, 32'h5 + OFFS_A, 2'h0);
    check({30'h0, abt_valid_q, abt_abort_q}, 32'h2);
    check({30'h0, ign_valid_q, ign_ignored_q}, 32'h2);
    send(MSM_KIND_TRANSLATED, 32'h6, 16'h0, 2'h0, 2'h0);
    expect_out(1'h1, 1'h0, 32'h6 + OFFS_A, 2'h0);
    // Back to back writes with distinct stream ids
    @(posedge clock);
    req_valid     <= 1'h1;
    req_stream_id <= 32'h10;
    @(posedge clock);
    req_stream_id <= 32'h11;
    #1;
    expect_out(1'h1, 1'h0, 32'h10 + OFFS_A, 2'h0);
    @(posedge clock);
    req_valid <= 1'h0;
    #1;
    expect_out(1'h1, 1'h0, 32'h11 + OFFS_A, 2'h0);
    $display("translated done");
  endtask : t_translated

  task automatic t_root_complex;
    send(MSM_KIND_RC_XLAT, 32'h0, 16'h1234, 2'h1, 2'h2);
    expect_out(1'h1, 1'h0, 32'h1234 + (C_B << 16) + OFFS_A, 2'h1);
    send(MSM_KIND_RC_DIRECT, 32'h0, 16'hABCD, 2'h1, 2'h3);
    expect_out(1'h1, 1'h0, 32'hABCD + (C_C << 16), 2'h1);
    send(MSM_KIND_ASSIGNED, 32'h77, 16'h0, 2'h0, 2'h0);
    expect_out(1'h1, 1'h0, 32'h77, 2'h0);
    $display("root complex done");
  endtask : t_root_complex

  task automatic t_illegal;
    send(MSM_KIND_PE, 32'h5, 16'h0, 2'h0, 2'h0);
    expect_out(1'h1, 1'h1, 32'hFFFF_FFFF, 2'h0);
    check({30'h0, abt_valid_q, abt_abort_q}, 32'h1);
    check({30'h0, ign_valid_q, ign_ignored_q}, 32'h1);
    send(MSM_KIND_UNTRUSTED, 32'h5, 16'h0, 2'h0, 2'h0);
    expect_out(1'h1, 1'h1, 32'hFFFF_FFFF, 2'h0);
    send(MSM_KIND_TRANSLATED, 32'h5, 16'h0, 2'h0, 2'h1);
    expect_out(1'h1, 1'h1, 32'hFFFF_FFFF, 2'h0);
    send(MSM_KIND_TRANSLATED, 32'hFFFF_FFF0, 16'h0, 2'h0, 2'h0);
    expect_out(1'h1, 1'h1, 32'hFFFF_FFFF, 2'h0);
    $display("illegal done");
  endtask : t_illegal

  task automatic t_groups;
    for (int t = 1; t < 4; t++) begin
      send(MSM_KIND_TRANSLATED, 32'h9, 16'h0, 2'h1, t[1:0]);
      expect_out(1'h1, 1'h0, 32'h9 + OFFS_A, 2'h1);
      check({30'h0, out_target_q}, {30'h0, t[1:0]});
    end
    @(posedge clock);
    #1;
    check({16'h0, taken_count_q}, {16'h0, exp_taken});
    check(taken_id_q, 32'h9 + OFFS_A);
    check({30'h0, taken_group_q}, 32'h1);
    $display("groups done");
  endtask : t_groups

  // Mapping must come back unchanged after a mid-run reset
  task automatic t_reset;
    send(MSM_KIND_TRANSLATED, 32'h5, 16'h0, 2'h0, 2'h0);
    // Write held present so reset must be what clears the outputs
    @(posedge clock);
    rst       <= 1'h1;
    req_valid <= 1'h1;
    repeat (2) @(posedge clock);
    #1;
    check({31'h0, out_valid_q}, 32'h0);
    check(out_source_id_q, 32'h0);
    @(posedge clock);
    rst       <= 1'h0;
    req_valid <= 1'h0;
    send(MSM_KIND_TRANSLATED, 32'h5, 16'h0, 2'h0, 2'h0);
    expect_out(1'h1, 1'h0, 32'h5 + OFFS_A, 2'h0);
    $display("reset done");
  endtask : t_reset

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #(2000 * 10);
    fail_count++;
    $display("watchdog expired at %0t", $time);
    print_verdict();
  end

  initial begin
    clock            = 1'h0;
    rst              = 1'h1;
    req_valid        = 1'h0;
    req_kind         = MSM_KIND_TRANSLATED;
    req_stream_id    = 32'h0;
    req_requester_id = 16'h0;
    req_home_group   = 2'h0;
    req_target       = 2'h0;
    fail_count       = 0;
    compares         = 0;
    exp_taken        = 16'h0;
    repeat (16) @(posedge clock);
    rst <= 1'h0;
    t_translated();
    t_root_complex();
    t_illegal();
    t_groups();
    t_reset();
    print_verdict();
  end
endmodule : test_msm_source_map
`default_nettype wire
